// ### rtl/conv_ctrl.sv
// Converter selection, sequencing, sleep start and result control
//
// Operation
// - Channel and reference writes land in a buffer, not the active copy.
// - When idle, buffer is copied to active selection every converter tick.
// - Active selection is frozen once a conversion starts.
// - Copying resumes in the last converter tick before done is set.
// - Start bit write begins conversion on next converter tick.
// - Free run channel change takes effect one result later.
// - Input above reference yields full-scale code.
// - Noise-reduction or idle sleep starts a conversion once core halts.
// - Sleep conversion completion raises interrupt to wake the core.
// - Interrupt request still posted if core woke earlier.
// - Core stays awake until a new sleep command.
// - Other sleep states leave the converter enabled.
// - Result registers hold the result once done flag is high.
// - Single-ended code is vin times 1024 over reference, unsigned.
// - Start bit reads one during conversion, cleared at single end.
// - Free-running mode restarts as soon as a conversion finishes.
//
// Chosen here: the placing of the registers and register access over APB.
`default_nettype none
module conv_ctrl import conv_ctrl_pkg::*; #(
    parameter int DIV = DIV_CYCLES
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sleep_adc_i,
    input wire logic core_halted_i,
    input wire logic [11:0] sample_i,
    output logic [CHAN_W-1:0] active_chan_o,
    output logic [REF_W-1:0] active_ref_o,
    output logic sample_hold_o,
    output logic conv_irq_o
);
    typedef struct packed {
        sel_s buf_sel;
        sel_s act_sel;
        logic enable;
        logic start;
        logic auto_trig;
        logic free_run;
        logic done;
        logic irq_en;
        logic first;
        logic [4:0] tick_cnt;
        conv_state_e state;
        logic pend_start;
        logic sleep_armed;
        logic [RES_W-1:0] result;
        logic [31:0] rdata;
        logic ready;
        logic err;
        logic irq;
        logic sh;
    } state_s;
    state_s q_r, q_nxt;

    logic tick;
    logic [RES_W-1:0] code;
    logic wr_acc;
    logic rd_acc;
    logic [4:0] conv_len;

    // ------------------------------------------------------------
    // Sub-blocks
    // ------------------------------------------------------------
    conv_tick_div #(.DIV(DIV)) u_div (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .run_i(q_r.enable),
        .tick_o(tick)
    );

    conv_result_fmt u_fmt (
        .sample_i(sample_i),
        .code_o(code)
    );

    assign wr_acc = psel && penable && pwrite;
    assign rd_acc = psel && !penable && !pwrite;
    assign conv_len = q_r.first ? 5'(FIRST_TICKS) : 5'(NORMAL_TICKS);

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        q_nxt = q_r;
        q_nxt.ready = 1'b0;
        q_nxt.err = 1'b0;
        q_nxt.sh = 1'b0;

        // Access phase answered one cycle after setup, zero wait states
        if (psel && !penable) begin
            q_nxt.ready = 1'b1;
        end
        if (psel && penable && q_r.ready) begin
            q_nxt.ready = 1'b0;
        end

        // Sleep arming: only the halt after a sleep request starts one
        if (!sleep_adc_i) begin
            q_nxt.sleep_armed = 1'b1;
        end

        // Register writes
        if (wr_acc && q_r.ready) begin
            case (paddr)
                SEL_OFFS: begin
                    q_nxt.buf_sel = pwdata[7:0];
                end
                CTRL_OFFS: begin
                    q_nxt.enable = pwdata[CTRL_ENABLE_BIT];
                    q_nxt.auto_trig = pwdata[CTRL_AUTO_BIT];
                    q_nxt.free_run = pwdata[CTRL_FREE_BIT];
                    q_nxt.irq_en = pwdata[CTRL_IE_BIT];
                    if (pwdata[CTRL_START_BIT] && pwdata[CTRL_ENABLE_BIT]) begin
                        q_nxt.start = 1'b1;
                        q_nxt.pend_start = 1'b1;
                    end
                    // Write one to clear; hardware set below wins
                    if (pwdata[CTRL_DONE_BIT]) begin
                        q_nxt.done = 1'b0;
                    end
                    if (!pwdata[CTRL_ENABLE_BIT]) begin
                        q_nxt.first = 1'b1;
                        q_nxt.state = ST_IDLE;
                        q_nxt.start = 1'b0;
                        q_nxt.pend_start = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end else if (psel && penable && q_r.ready) begin
            case (paddr)
                SEL_OFFS, CTRL_OFFS, RES_LO_OFFS, RES_HI_OFFS, ACT_OFFS: begin
                end
                default: begin
                end
            endcase
        end

        // Noise-reduction or idle sleep start once the core halts
        if (sleep_adc_i && core_halted_i && q_r.sleep_armed && q_r.enable
                && q_r.state == ST_IDLE) begin
            q_nxt.sleep_armed = 1'b0;
            q_nxt.start = 1'b1;
            q_nxt.pend_start = 1'b1;
        end

        // Converter sequencing on converter clock ticks
        if (tick && q_r.enable) begin
            case (q_r.state)
                ST_IDLE: begin
                    q_nxt.act_sel = q_r.buf_sel;
                    if (q_r.pend_start) begin
                        q_nxt.pend_start = 1'b0;
                        q_nxt.state = ST_CONV;
                        // Start tick counts as zero: done lands conv_len + 1 ticks later
                        q_nxt.tick_cnt = 5'd0;
                    end
                end
                ST_CONV: begin
                    q_nxt.tick_cnt = q_r.tick_cnt + 5'd1;
                    if (q_r.tick_cnt == 5'd1) begin
                        q_nxt.sh = 1'b1;
                    end
                    if (q_r.tick_cnt == conv_len - 5'd1) begin
                        q_nxt.act_sel = q_r.buf_sel;
                    end
                    if (q_r.tick_cnt == conv_len) begin
                        q_nxt.result = code;
                        q_nxt.done = 1'b1;
                        q_nxt.first = 1'b0;
                        q_nxt.act_sel = q_r.buf_sel;
                        if (q_r.auto_trig && q_r.free_run) begin
                            // Next conversion uses the selection copied in
                            // this done tick, so a later change lags one result
                            q_nxt.tick_cnt = 5'd0;
                        end else begin
                            q_nxt.state = ST_IDLE;
                            q_nxt.start = 1'b0;
                        end
                    end
                end
                default: begin
                    q_nxt.state = ST_IDLE;
                end
            endcase
        end

        // A disable write wins over a start from any source
        if (!q_nxt.enable) begin
            q_nxt.state = ST_IDLE;
            q_nxt.start = 1'b0;
            q_nxt.pend_start = 1'b0;
            q_nxt.first = 1'b1;
        end

        // Interrupt is posted whether or not the core already woke
        q_nxt.irq = q_nxt.done && q_nxt.irq_en;

        // Read data captured in setup, stable through the access phase
        if (rd_acc) begin
            case (paddr)
                SEL_OFFS: q_nxt.rdata = {24'h000000, q_r.buf_sel};
                CTRL_OFFS: q_nxt.rdata = {25'h0000000, q_r.first,
                    q_r.irq_en, q_r.done, q_r.free_run, q_r.auto_trig,
                    q_r.start, q_r.enable};
                RES_LO_OFFS: q_nxt.rdata = {24'h000000, q_r.result[7:0]};
                RES_HI_OFFS: q_nxt.rdata = {30'h00000000, q_r.result[9:8]};
                ACT_OFFS: q_nxt.rdata = {24'h000000, q_r.act_sel};
                default: q_nxt.rdata = 32'h00000000;
            endcase
        end
        if (psel && !penable) begin
            q_nxt.err = !(paddr == SEL_OFFS || paddr == CTRL_OFFS
                || paddr == RES_LO_OFFS || paddr == RES_HI_OFFS
                || paddr == ACT_OFFS);
        end else if (psel && penable && !q_r.ready) begin
            q_nxt.err = q_r.err;
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            q_r <= '0;
            q_r.first <= 1'b1;
            q_r.sleep_armed <= 1'b1;
            q_r.state <= ST_IDLE;
        end else begin
            q_r <= q_nxt;
        end
    end

    // Entering other sleep states never touches the enable bit
    assign active_chan_o = q_r.act_sel.chan_sel;
    assign active_ref_o = q_r.act_sel.ref_sel;
    assign sample_hold_o = q_r.sh;
    assign conv_irq_o = q_r.irq;
    assign prdata = q_r.rdata;
    assign pready = q_r.ready;
    assign pslverr = q_r.err;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_sel_frozen_conv: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        (q_r.state == ST_CONV && q_r.tick_cnt < conv_len - 5'd1)
        |=> $stable(q_r.act_sel))
        else $error("active selection moved mid conversion");

    a_idle_copy_sel: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        (tick && q_r.enable && q_r.state == ST_IDLE)
        |=> q_r.act_sel == $past(q_r.buf_sel))
        else $error("idle selection not copied");

    a_resume_copy: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        (tick && q_r.enable && q_r.state == ST_CONV
        && q_r.tick_cnt == conv_len - 5'd1)
        |=> q_r.act_sel == $past(q_r.buf_sel))
        else $error("selection copy did not resume before done");

    a_buf_write: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        (wr_acc && q_r.ready && paddr == SEL_OFFS)
        |=> q_r.buf_sel == $past(pwdata[7:0]))
        else $error("selection write missed the buffer");

    a_start_on_tick: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        (q_r.state == ST_IDLE && q_nxt.state == ST_CONV) |-> tick)
        else $error("conversion began off a converter tick");

    a_start_reads_one: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        q_r.state == ST_CONV |-> q_r.start)
        else $error("start bit low during conversion");

    a_done_sets_irq: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        (q_r.done && q_r.irq_en) |-> conv_irq_o)
        else $error("interrupt not raised on done");

    a_result_clamped: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        (tick && q_r.state == ST_CONV && q_r.tick_cnt == conv_len
        && sample_i > 12'h3FF) |=> q_r.result == FULL_SCALE)
        else $error("over-range sample not clamped");

    a_result_code: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        (tick && q_r.state == ST_CONV && q_r.tick_cnt == conv_len
        && sample_i <= 12'h3FF)
        |=> q_r.result == $past(sample_i[RES_W-1:0]))
        else $error("in-range sample not stored as is");

    a_single_clears: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        (tick && q_r.enable && q_r.state == ST_CONV
        && q_r.tick_cnt == conv_len && !(q_r.auto_trig && q_r.free_run))
        |=> !q_r.start && q_r.done)
        else $error("single conversion end wrong");

    a_free_restart: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        (tick && q_r.enable && q_r.state == ST_CONV
        && q_r.tick_cnt == conv_len && q_r.auto_trig && q_r.free_run
        && !(wr_acc && q_r.ready))
        |=> q_r.state == ST_CONV && q_r.tick_cnt == 5'd0 && q_r.done)
        else $error("free running did not restart");

    a_sleep_starts: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        (sleep_adc_i && core_halted_i && q_r.sleep_armed && q_nxt.enable
        && q_r.enable && q_r.state == ST_IDLE)
        |=> (q_r.pend_start || q_r.state == ST_CONV))
        else $error("sleep did not start a conversion");

    a_sleep_once: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        (!q_r.sleep_armed && sleep_adc_i) |=> !q_r.sleep_armed)
        else $error("sleep start rearmed during one sleep");

    a_enable_kept: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        (q_r.enable && !(wr_acc && q_r.ready && paddr == CTRL_OFFS))
        |=> q_r.enable)
        else $error("enable dropped without a control write");

    a_disable_aborts: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        (wr_acc && q_r.ready && paddr == CTRL_OFFS
        && !pwdata[CTRL_ENABLE_BIT])
        |=> q_r.state == ST_IDLE && !q_r.start && q_r.first)
        else $error("disable write did not stop the converter");

    a_pready_setup: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        (psel && !penable) |=> pready)
        else $error("access phase not answered at once");

    a_err_ready: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        pslverr |-> pready)
        else $error("error response without ready");
endmodule
`default_nettype wire

// ### rtl/conv_ctrl_pkg.sv
// Shared constants, register map and types of the converter control block
`default_nettype none
package conv_ctrl_pkg;
    // APB register byte offsets
    localparam logic [7:0] SEL_OFFS = 8'h00;
    localparam logic [7:0] CTRL_OFFS = 8'h04;
    localparam logic [7:0] RES_LO_OFFS = 8'h08;
    localparam logic [7:0] RES_HI_OFFS = 8'h0C;
    localparam logic [7:0] ACT_OFFS = 8'h10;
    // Control register field positions
    localparam int CTRL_ENABLE_BIT = 0;
    localparam int CTRL_START_BIT = 1;
    localparam int CTRL_AUTO_BIT = 2;
    localparam int CTRL_FREE_BIT = 3;
    localparam int CTRL_DONE_BIT = 4;
    localparam int CTRL_IE_BIT = 5;
    localparam int CTRL_FIRST_BIT = 6;
    // Selection and result register fields, reset values
    localparam int CHAN_W = 6;
    localparam int REF_W = 2;
    localparam int REF_LSB = 6;
    localparam int RES_W = 10;
    localparam logic [RES_W-1:0] FULL_SCALE = 10'h3FF;
    localparam logic [RES_W-1:0] RES_RESET = 10'h000;
    localparam logic [7:0] SEL_RESET = 8'h00;
    // Timing: converter clock divided from the 10 MHz system clock
    localparam int CLK_HZ = 10_000_000;
    localparam int CONV_CLK_HZ = 200_000;
    localparam int DIV_CYCLES = CLK_HZ / CONV_CLK_HZ;
    localparam int NORMAL_TICKS = 13;
    localparam int FIRST_TICKS = 25;

    typedef struct packed {
        logic [REF_W-1:0] ref_sel;
        logic [CHAN_W-1:0] chan_sel;
    } sel_s;

    typedef enum logic [1:0] {ST_IDLE, ST_CONV} conv_state_e;
endpackage
`default_nettype wire

// ### rtl/conv_tick_div.sv
// Divider that makes the one-cycle converter clock enable
`default_nettype none
module conv_tick_div import conv_ctrl_pkg::*; #(
    parameter int DIV = DIV_CYCLES
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic run_i,
    output logic tick_o
);
    typedef struct packed {
        logic [15:0] cnt;
        logic tick;
    } div_s;
    div_s q_r, q_nxt;

    always_comb begin
        q_nxt = q_r;
        q_nxt.tick = 1'b0;
        if (!run_i) begin
            // Held in reset while the converter is off
            q_nxt.cnt = 16'h0000;
        end else if (q_r.cnt == 16'(DIV - 1)) begin
            q_nxt.cnt = 16'h0000;
            q_nxt.tick = 1'b1;
        end else begin
            q_nxt.cnt = q_r.cnt + 16'h0001;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            q_r <= '0;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign tick_o = q_r.tick;
endmodule
`default_nettype wire

// ### rtl/conv_result_fmt.sv
// Single-ended result clamp to the ten-bit range, sample passed through unscaled
`default_nettype none
module conv_result_fmt import conv_ctrl_pkg::*; (
    input wire logic [11:0] sample_i,
    output logic [RES_W-1:0] code_o
);
    // Sample is vin*1024/vref, may exceed full scale when vin > vref
    always_comb begin
        if (sample_i > {2'b00, FULL_SCALE}) begin
            code_o = FULL_SCALE;
        end else begin
            code_o = sample_i[RES_W-1:0];
        end
    end
endmodule
`default_nettype wire

// ### sim/core_model.sv
// Processor core model: enters sleep on request, wakes on interrupts
`default_nettype none
module core_model (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic sleep_req_i,
    input wire logic adc_mode_i,
    input wire logic wake_i,
    input wire logic irq_i,
    output logic sleep_adc_o,
    output logic halted_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic asleep_r;
    // ----------------------------------------
    // Sleep entry and wake-up
    // ----------------------------------------
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            asleep_r <= 1'b0;
            sleep_adc_o <= 1'b0;
            halted_o <= 1'b0;
        end else if (sleep_req_i) begin
            asleep_r <= 1'b1;
            sleep_adc_o <= adc_mode_i;
        end else if (asleep_r && (irq_i || wake_i)) begin
            // Any interrupt wakes; active until the next request
            asleep_r <= 1'b0;
            sleep_adc_o <= 1'b0;
            halted_o <= 1'b0;
        end else if (asleep_r) begin
            // Clock stops one cycle after the sleep command
            halted_o <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// ### sim/adc_select_sleep_result_ctrl_tb.sv
// Self-checking bench for the converter control block
`default_nettype none
module adc_select_sleep_result_ctrl_tb import conv_ctrl_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int D = 4;
    logic clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, se, sleep_adc, halted, shold, irq;
    logic sleep_req = 1'b0, adc_mode = 1'b0, wake = 1'b0;
    logic [11:0] sample = 12'h000;
    logic [CHAN_W-1:0] achan;
    logic [REF_W-1:0] external_reference_pin;
    int err_count = 0, total_checks = 0, n, shc;
    conv_ctrl #(.DIV(D)) u_dut (.clk_i(clk_i), .resetn_i(resetn_i),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sleep_adc_i(sleep_adc), .core_halted_i(halted),
        .sample_i(sample), .active_chan_o(achan), .active_ref_o(external_reference_pin),
        .sample_hold_o(shold), .conv_irq_o(irq));
    core_model u_core (.clk_i(clk_i), .resetn_i(resetn_i),
        .sleep_req_i(sleep_req), .adc_mode_i(adc_mode), .wake_i(wake),
        .irq_i(irq), .sleep_adc_o(sleep_adc), .halted_o(halted));
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] got, exp, input string m);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %0t %s", $time, m);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk_i);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_i);
        penable <= 1'b1;
        @(posedge clk_i);
        while (pready !== 1'b1) @(posedge clk_i);
        rd = prdata;
        se = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wait_irq();
        n = 0;
        shc = 0;
        while (irq !== 1'b1 && n < 300) begin
            @(posedge clk_i);
            n++;
            if (shold === 1'b1) shc++;
        end
        if (irq !== 1'b1) begin
            err_count++;
            $display("MISMATCH %0t interrupt wait ran out", $time);
        end
    endtask
    task automatic sleep_cmd(input logic m);
        adc_mode <= m;
        sleep_req <= 1'b1;
        @(posedge clk_i);
        sleep_req <= 1'b0;
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_regs();
        apb(0, SEL_OFFS, 0);
        chk(rd, 32'(SEL_RESET), "selection reset");
        apb(0, CTRL_OFFS, 0);
        chk(rd, 32'h40, "control reset");
        apb(1, 8'h24, 32'hFF);
        chk(32'(se), 1, "unmapped write error");
        apb(0, 8'h24, 0);
        chk({rd[30:0], se}, 1, "unmapped read");
        $display("test regs done");
    endtask
    task automatic t_first();
        // Selections only reach the active copy once the converter is on
        apb(1, CTRL_OFFS, 32'h01);
        apb(1, SEL_OFFS, 32'h45);
        repeat (D + 1) @(posedge clk_i);
        chk(32'({external_reference_pin, achan}), 32'h45, "idle copy");
        sample <= 12'h5A5;
        apb(1, CTRL_OFFS, 32'h23);
        // Reselect only after one converter clock has passed
        repeat (D) @(posedge clk_i);
        apb(1, SEL_OFFS, 32'h12);
        apb(0, CTRL_OFFS, 0);
        chk(32'(rd[1]), 1, "start bit busy");
        chk(32'({external_reference_pin, achan}), 32'h45, "frozen");
        apb(0, ACT_OFFS, 0);
        chk(rd, 32'h45, "active readback");
        apb(0, SEL_OFFS, 0);
        chk(rd, 32'h12, "buffer readback");
        wait_irq();
        chk(32'({external_reference_pin, achan}), 32'h12, "copy resumes");
        apb(0, CTRL_OFFS, 0);
        chk(rd & 32'h52, 32'h10, "done, start cleared");
        apb(0, RES_LO_OFFS, 0);
        chk(rd, 32'hFF, "clamp low");
        apb(0, RES_HI_OFFS, 0);
        chk(rd, 32'h3, "clamp high");
        $display("test first done");
    endtask
    task automatic t_norm();
        // First result after the reference switch is thrown away
        apb(1, CTRL_OFFS, 32'h33);
        wait_irq();
        // Inputs held still while the conversion runs
        sample <= 12'h1A3;
        apb(1, CTRL_OFFS, 32'h33);
        wait_irq();
        chk(32'(n >= 13 * D && n <= 14 * D + 2), 1, "timing");
        chk(32'(shc), 1, "one sample pulse");
        apb(0, RES_LO_OFFS, 0);
        chk(rd, 32'hA3, "result low");
        apb(0, RES_HI_OFFS, 0);
        chk(rd, 32'h1, "result high");
        $display("test normal done");
    endtask
    task automatic t_free();
        apb(1, SEL_OFFS, 32'h03);
        apb(1, CTRL_OFFS, 32'h3F);
        wait_irq();
        // Safe point: flag still set, so the change is deterministic
        apb(1, SEL_OFFS, 32'h07);
        chk(32'(achan), 32'h3, "old channel kept");
        apb(1, CTRL_OFFS, 32'h3D);
        wait_irq();
        chk(32'(n <= 14 * D + 2), 1, "restart at once");
        chk(32'(achan), 32'h7, "new channel next");
        apb(0, CTRL_OFFS, 0);
        chk(32'(rd[1]), 1, "start stays high");
        apb(1, CTRL_OFFS, 32'h00);
        $display("test free done");
    endtask
    task automatic t_sleep();
        sample <= 12'h0C8;
        // Enabled, idle, single mode and interrupt enabled first
        apb(1, CTRL_OFFS, 32'h31);
        @(posedge clk_i);
        chk(32'(irq), 0, "irq cleared");
        sleep_cmd(1'b1);
        wait_irq();
        chk(32'(n < 300), 1, "sleep start");
        repeat (2) @(posedge clk_i);
        chk(32'(halted), 0, "woken by irq");
        apb(0, RES_LO_OFFS, 0);
        chk(rd, 32'hC8, "sleep result");
        apb(1, CTRL_OFFS, 32'h31);
        sleep_cmd(1'b1);
        repeat (2 * D) @(posedge clk_i);
        wake <= 1'b1;
        @(posedge clk_i);
        wake <= 1'b0;
        wait_irq();
        chk(32'(irq), 1, "irq after early wake");
        apb(1, CTRL_OFFS, 32'h31);
        sleep_cmd(1'b0);
        repeat (15 * D) @(posedge clk_i);
        apb(0, CTRL_OFFS, 0);
        chk(rd & 32'h13, 32'h01, "other sleep");
        $display("test sleep done");
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // ----------------------------------------
    // Clock, watchdog and main sequence
    // ----------------------------------------
    initial begin
        forever #50 clk_i = ~clk_i;
    end
    initial begin
        repeat (20000) @(posedge clk_i);
        err_count++;
        conclude();
    end
    initial begin
        repeat (10) @(posedge clk_i);
        resetn_i <= 1'b1;
        t_regs();
        t_first();
        t_norm();
        t_free();
        t_sleep();
        conclude();
    end
endmodule
`default_nettype wire
